// ==== core/itr_count_element.v ====
`timescale 1ns/1ps
`include "itr_defines.vh"

// ==========================================================================
// Decrementing element of one counter with its output waveform
// ==========================================================================
module itr_count_element #(
  parameter WIDTH = 16
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire tick,
  input wire gate,
  input wire [2:0] mode,
  input wire modeWrite,
  input wire loadReq,
  input wire [WIDTH-1:0] divisor,
  output wire [WIDTH-1:0] count,
  output wire outLevel,
  output wire loaded
);

  reg [WIDTH-1:0] count_q;
  reg out_q;
  reg pending_q;
  reg loaded_q;
  wire [2:0] effMode;

  // Modes 6 and 7 behave as 2 and 3.
  assign effMode = (mode[2:1] == `ITR_MODE_ALIAS) ? {1'b0, mode[1:0]} : mode;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      count_q <= `ITR_COUNT_ZERO;
      out_q <= 1'b1;
      pending_q <= 1'b0;
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b0;
      if (modeWrite) begin
        out_q <= (effMode != `ITR_MODE_TC);
        pending_q <= 1'b0;
      end else begin
        if (tick) begin
          if (pending_q) begin
            // A pending divisor enters the element here; mode 2 also reloads the divisor at the end of each period, mode 3 at the end of each half period.
            count_q <= divisor; // R8
            pending_q <= 1'b0;
            loaded_q <= 1'b1; // R7
            if (effMode == `ITR_MODE_TC) begin
              out_q <= 1'b0;
            end
          end else if (gate) begin
            case (effMode)
              `ITR_MODE_RATE: begin
                if (count_q == `ITR_COUNT_ONE) begin
                  count_q <= divisor; // R13
                  out_q <= 1'b1;
                end else begin
                  count_q <= count_q - `ITR_COUNT_ONE; // R20
                  out_q <= (count_q != `ITR_COUNT_TWO);
                end
              end
              `ITR_MODE_SQUARE: begin
                if (count_q <= `ITR_COUNT_TWO) begin
                  count_q <= divisor; // R13
                  out_q <= ~out_q;
                end else begin
                  count_q <= count_q - `ITR_COUNT_TWO;
                end
              end
              default: begin
                count_q <= count_q - `ITR_COUNT_ONE; // R20
                if (count_q == `ITR_COUNT_ONE) begin
                  out_q <= 1'b1;
                end
              end
            endcase
          end
        end
        // A write arriving with the load edge still queues its own load.
        if (loadReq) begin
          pending_q <= 1'b1;
        end
      end
    end
  end

  assign count = count_q;
  assign outLevel = out_q;
  assign loaded = loaded_q;

endmodule // itr_count_element

// ==== core/itr_defines.vh ====
`ifndef ITR_DEFINES_VH
`define ITR_DEFINES_VH

// ==========================================================================
// Bus decode
// ==========================================================================
// Address of the control word port; the three lower addresses are counters.
`define ITR_ADDR_CTRL 2'h3

// ==========================================================================
// Control word fields
// ==========================================================================
`define ITR_CW_SC 7:6
`define ITR_CW_RW 5:4
`define ITR_CW_MODE 3:1
`define ITR_CW_SETUP 5:0
`define ITR_CW_COUNT_N 5
`define ITR_CW_STATUS_N 4
`define ITR_CW_SEL_LO 1
`define ITR_SC_READBACK 2'h3

// Byte width codes.
`define ITR_RW_LATCH 2'h0
`define ITR_RW_LSB 2'h1
`define ITR_RW_MSB 2'h2
`define ITR_RW_BOTH 2'h3

// ==========================================================================
// Counting modes
// ==========================================================================
`define ITR_MODE_TC 3'h0
`define ITR_MODE_RATE 3'h2
`define ITR_MODE_SQUARE 3'h3
`define ITR_MODE_ALIAS 2'h3

// ==========================================================================
// Constants
// ==========================================================================
`define ITR_BYTE_ZERO 8'h00
`define ITR_COUNT_ZERO 16'h0000
`define ITR_COUNT_ONE 16'h0001
`define ITR_COUNT_TWO 16'h0002
`define ITR_SETUP_ZERO 6'h00
// Idle pin levels: strobes and chip select high, everything else low.
`define ITR_PIN_WIDTH 20
`define ITR_PIN_RESET 20'h0_0007

`endif

// ==== core/itr_pin_sync.v ====
`timescale 1ns/1ps
`include "itr_defines.vh"

// ==========================================================================
// Two-stage synchroniser for pins arriving from outside the clock domain
// ==========================================================================
module itr_pin_sync #(
  parameter WIDTH = `ITR_PIN_WIDTH,
  parameter [WIDTH-1:0] RESET_VALUE = `ITR_PIN_RESET
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] pinIn,
  output wire [WIDTH-1:0] pinSync
);

  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1_q <= RESET_VALUE;
      stage2_q <= RESET_VALUE;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
    end
  end

  assign pinSync = stage2_q;

endmodule // itr_pin_sync

// ==== core/itr_readback_timer.v ====
`timescale 1ns/1ps
`include "itr_defines.vh"

// Functional notes
// R1: Read-back acts only on counters whose select bits D3..D1 are one.
// R2: Count bit D5 low captures each selected counter's count into its hold.
// R3: Capture holds until its own counter is read or reprogrammed.
// R4: Further count captures before reading are ignored; first value stays.
// R5: Status bit D4 low captures status; status only read after capture.
// R6: Status bits 5..0 are last setup bits; bit 7 is output level.
// R7: Status bit 6 shows the written divisor is not yet in the element.
// R8: Counts captured before the divisor loads show the element's old value.
// R9: Further status captures before reading are ignored; first status stays.
// R10: D5 and D4 both low capture count and status with same ignore rules.
// R11: Status reads first, then captured count bytes, then live count.
// R12: Host reads the programmed byte count in programmed order.
// R13: Loaded count divides the counter's input clock; third counter gives baud.
// R14: Host picks synchronous divisor as input clock over baud rate.
// R15: Host picks asynchronous divisor with multiplier 16 or 64.
// R16: Host uses multiplier one only with synchronised clocks.
// R17: Host sets mode 0 then loads count for terminal-count interval.
// R18: First two counters can be cascaded in series.
// R19: Three low addresses are counters, fourth takes control; its read is no-op.
// R20: Element decrements each active input edge when enabled; captures same cycle.
module itr_readback_timer #(
  parameter WIDTH = 16
) (
  input wire ref_clk,
  input wire sys_rst,
  input wire chipSelectN,
  input wire readN,
  input wire writeN,
  input wire [1:0] addr,
  input wire [7:0] dataIn,
  output wire [7:0] dataOut,
  output wire dataOeN,
  input wire [2:0] counterClk,
  input wire [2:0] counterGate,
  input wire cascadeEnable,
  output wire periodicIrqClockA,
  output wire periodicClockB,
  output wire transmitBitClock,
  output wire receiveBitClock
);

  // ========================================================================
  // Byte selection
  // ========================================================================
  function [7:0] pickByte;
    input [15:0] value;
    input [1:0] rw;
    input msbNext;
    begin
      if (rw == `ITR_RW_MSB || (rw == `ITR_RW_BOTH && msbNext)) begin
        pickByte = value[15:8];
      end else begin
        pickByte = value[7:0];
      end
    end
  endfunction

  // ========================================================================
  // Pin synchronisation and strobe edges
  // ========================================================================
  wire [`ITR_PIN_WIDTH-1:0] pinSync;
  wire csS;
  wire rdS;
  wire wrS;
  wire [1:0] addrS;
  wire [7:0] dataS;
  wire [2:0] clkS;
  wire [2:0] gateS;
  wire cascS;

  itr_pin_sync #(
    .WIDTH(`ITR_PIN_WIDTH),
    .RESET_VALUE(`ITR_PIN_RESET)
  ) uPinSync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pinIn({cascadeEnable, counterGate, counterClk, dataIn, addr, writeN, readN,
      chipSelectN}),
    .pinSync(pinSync)
  );

  assign {cascS, gateS, clkS, dataS, addrS, wrS, rdS, csS} = pinSync;

  reg csP_q;
  reg rdP_q;
  reg wrP_q;
  reg [1:0] addrP_q;
  reg [7:0] dataP_q;
  reg [2:0] clkP_q;
  reg out0P_q;
  wire wrTake;
  wire rdEnd;
  wire [2:0] tick;
  wire [2:0] outVec;
  wire [2:0] loaded;
  wire [3*WIDTH-1:0] liveCount;

  // A write is taken, and a read finished, on the rising strobe edge.
  assign wrTake = !wrP_q && wrS && !csP_q;
  assign rdEnd = !rdP_q && rdS && !csP_q;

  assign tick[0] = clkP_q[0] && !clkS[0];
  assign tick[1] = cascS ? (out0P_q && !outVec[0]) : (clkP_q[1] && !clkS[1]); // R18
  assign tick[2] = clkP_q[2] && !clkS[2];

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      csP_q <= 1'b1;
      rdP_q <= 1'b1;
      wrP_q <= 1'b1;
      addrP_q <= 2'h0;
      dataP_q <= `ITR_BYTE_ZERO;
      clkP_q <= 3'h0;
      out0P_q <= 1'b1;
    end else begin
      csP_q <= csS;
      rdP_q <= rdS;
      wrP_q <= wrS;
      addrP_q <= addrS;
      dataP_q <= dataS;
      clkP_q <= clkS;
      out0P_q <= outVec[0];
    end
  end

  // ========================================================================
  // Per-counter state
  // ========================================================================
  reg [5:0] setup_q [0:2];
  reg [WIDTH-1:0] divisor_q [0:2];
  reg [7:0] lsbHold_q [0:2];
  reg [WIDTH-1:0] heldCount_q [0:2];
  reg [7:0] heldStatus_q [0:2];
  reg [2:0] writeMsb_q;
  reg [2:0] readMsb_q;
  reg [2:0] cntLatched_q;
  reg [2:0] stLatched_q;
  reg [2:0] nullCount_q;
  reg [2:0] loadReq_q;
  reg [2:0] modeWrite_q;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gCounter
      itr_count_element #(
        .WIDTH(WIDTH)
      ) uElement (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .tick(tick[g]),
        .gate(gateS[g]),
        .mode(setup_q[g][`ITR_CW_MODE]),
        .modeWrite(modeWrite_q[g]),
        .loadReq(loadReq_q[g]),
        .divisor(divisor_q[g]),
        .count(liveCount[g*WIDTH +: WIDTH]),
        .outLevel(outVec[g]),
        .loaded(loaded[g])
      );
    end
  endgenerate

  // ========================================================================
  // Control words, count writes and read sequencing
  // ========================================================================
  integer i;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      for (i = 0; i < 3; i = i + 1) begin
        setup_q[i] <= `ITR_SETUP_ZERO;
        divisor_q[i] <= `ITR_COUNT_ZERO;
        lsbHold_q[i] <= `ITR_BYTE_ZERO;
        heldCount_q[i] <= `ITR_COUNT_ZERO;
        heldStatus_q[i] <= `ITR_BYTE_ZERO;
      end
      writeMsb_q <= 3'h0;
      readMsb_q <= 3'h0;
      cntLatched_q <= 3'h0;
      stLatched_q <= 3'h0;
      nullCount_q <= 3'h0;
      loadReq_q <= 3'h0;
      modeWrite_q <= 3'h0;
    end else begin
      loadReq_q <= 3'h0;
      modeWrite_q <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        // A load clears the flag; a write in the same cycle sets it again.
        if (loaded[i]) begin
          nullCount_q[i] <= 1'b0; // R7
        end
        if (wrTake && addrP_q == `ITR_ADDR_CTRL) begin // R19
          if (dataP_q[`ITR_CW_SC] == `ITR_SC_READBACK) begin
            if (dataP_q[`ITR_CW_SEL_LO + i]) begin // R1
              if (!dataP_q[`ITR_CW_COUNT_N] && !cntLatched_q[i]) begin // R4 R10
                heldCount_q[i] <= liveCount[i*WIDTH +: WIDTH]; // R2 R8 R20
                cntLatched_q[i] <= 1'b1; // R2
              end
              if (!dataP_q[`ITR_CW_STATUS_N] && !stLatched_q[i]) begin // R9 R10
                heldStatus_q[i] <= {outVec[i], nullCount_q[i], setup_q[i]}; // R5 R6 R7
                stLatched_q[i] <= 1'b1; // R5
              end
            end
          end else if (dataP_q[`ITR_CW_SC] == i[1:0]) begin
            if (dataP_q[`ITR_CW_RW] == `ITR_RW_LATCH) begin
              if (!cntLatched_q[i]) begin // R4
                heldCount_q[i] <= liveCount[i*WIDTH +: WIDTH];
                cntLatched_q[i] <= 1'b1;
              end
            end else begin
              // Reprogramming drops any capture and restarts byte order.
              setup_q[i] <= dataP_q[`ITR_CW_SETUP]; // R6
              writeMsb_q[i] <= 1'b0;
              readMsb_q[i] <= 1'b0;
              cntLatched_q[i] <= 1'b0; // R3
              stLatched_q[i] <= 1'b0;
              nullCount_q[i] <= 1'b1; // R7
              modeWrite_q[i] <= 1'b1;
            end
          end
        end
        if (wrTake && addrP_q == i[1:0]) begin // R19
          case (setup_q[i][`ITR_CW_RW])
            `ITR_RW_LSB: begin
              divisor_q[i] <= {`ITR_BYTE_ZERO, dataP_q}; // R13
              loadReq_q[i] <= 1'b1;
              nullCount_q[i] <= 1'b1; // R7
            end
            `ITR_RW_MSB: begin
              divisor_q[i] <= {dataP_q, `ITR_BYTE_ZERO}; // R13
              loadReq_q[i] <= 1'b1;
              nullCount_q[i] <= 1'b1; // R7
            end
            `ITR_RW_BOTH: begin
              if (writeMsb_q[i]) begin
                divisor_q[i] <= {dataP_q, lsbHold_q[i]}; // R13
                loadReq_q[i] <= 1'b1;
                nullCount_q[i] <= 1'b1; // R7
                writeMsb_q[i] <= 1'b0;
              end else begin
                lsbHold_q[i] <= dataP_q;
                writeMsb_q[i] <= 1'b1;
              end
            end
            default: begin
              writeMsb_q[i] <= 1'b0;
            end
          endcase
        end
        if (rdEnd && addrP_q == i[1:0]) begin
          if (stLatched_q[i]) begin
            stLatched_q[i] <= 1'b0; // R11
          end else if (cntLatched_q[i]) begin
            // Only this counter's capture is released.
            if (setup_q[i][`ITR_CW_RW] == `ITR_RW_BOTH && !readMsb_q[i]) begin // R12
              readMsb_q[i] <= 1'b1;
            end else begin
              readMsb_q[i] <= 1'b0;
              cntLatched_q[i] <= 1'b0; // R3
            end
          end else if (setup_q[i][`ITR_CW_RW] == `ITR_RW_BOTH) begin
            readMsb_q[i] <= ~readMsb_q[i]; // R12
          end
        end
      end
    end
  end

  // ========================================================================
  // Read data path
  // ========================================================================
  reg [7:0] readByte;
  reg readHit;
  reg [7:0] dataOut_q;
  reg dataOeN_q;
  integer j;

  always @* begin
    readByte = `ITR_BYTE_ZERO;
    readHit = !csS && !rdS && (addrS != `ITR_ADDR_CTRL); // R19
    for (j = 0; j < 3; j = j + 1) begin
      if (addrS == j[1:0]) begin
        if (stLatched_q[j]) begin
          readByte = heldStatus_q[j]; // R11
        end else if (cntLatched_q[j]) begin
          readByte = pickByte(heldCount_q[j], setup_q[j][`ITR_CW_RW], readMsb_q[j]); // R11
        end else begin
          readByte = pickByte(liveCount[j*WIDTH +: WIDTH], setup_q[j][`ITR_CW_RW],
            readMsb_q[j]);
        end
      end
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      dataOut_q <= `ITR_BYTE_ZERO;
      dataOeN_q <= 1'b1;
    end else begin
      dataOut_q <= readByte;
      dataOeN_q <= !readHit;
    end
  end

  assign dataOut = dataOut_q;
  assign dataOeN = dataOeN_q;

  // ========================================================================
  // Counter outputs
  // ========================================================================
  assign periodicIrqClockA = outVec[0];
  assign periodicClockB = outVec[1];
  assign transmitBitClock = outVec[2]; // R13
  assign receiveBitClock = outVec[2]; // R13

endmodule // itr_readback_timer

// ==== verif/itr_host_model.sv ====
`timescale 1ns/1ps

// ========================================
// Host processor model on the counter bus
// ========================================
module itr_host_model (
  input wire ref_clk,
  input wire [7:0] dataOut,
  input wire dataOeN,
  output reg chipSelectN,
  output reg readN,
  output reg writeN,
  output reg [1:0] addr,
  output reg [7:0] dataIn
);
  initial begin
    chipSelectN = 1'b1;
    readN = 1'b1;
    writeN = 1'b1;
    addr = 2'h0;
    dataIn = 8'h00;
  end

  // Address and data stay put well past the rising write strobe.
  task busWrite(input [1:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      addr <= a;
      dataIn <= d;
      chipSelectN <= 1'b0;
      writeN <= 1'b0;
      repeat (4) @(posedge ref_clk);
      writeN <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chipSelectN <= 1'b1;
      dataIn <= ~d;
      repeat (3) @(posedge ref_clk);
    end
  endtask

  // The strobe is held for a bounded time; sawOe tells whether the device answered.
  task busRead(input [1:0] a, output [7:0] d, output sawOe);
    integer i;
    begin
      sawOe = 1'b0;
      @(posedge ref_clk);
      addr <= a;
      chipSelectN <= 1'b0;
      readN <= 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
        @(posedge ref_clk);
        if (dataOeN === 1'b0)
          sawOe = 1'b1;
      end
      d = dataOut;
      readN <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chipSelectN <= 1'b1;
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule // itr_host_model

// ==== verif/itr_readback_timer_monitor.sv ====
`timescale 1ns/1ps

// ========================================
// Port checker for the read-back timer
// ========================================
module itr_readback_timer_monitor (
  input wire ref_clk,
  input wire sys_rst,
  input wire chipSelectN,
  input wire readN,
  input wire writeN,
  input wire [1:0] addr,
  input wire dataOeN,
  input wire [2:0] counterClk,
  input wire [2:0] counterGate,
  input wire cascadeEnable,
  input wire periodicIrqClockA,
  input wire periodicClockB,
  input wire transmitBitClock,
  input wire receiveBitClock
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_answer_cause: assert property ($fell(dataOeN) |->
    !$past(readN, 3) && !$past(chipSelectN, 3) && $past(addr, 3) != 2'h3)
    else $error("Data bus driven without a counter read");
  a_ctrl_read_noop: assert property (
    (!readN && !chipSelectN && addr == 2'h3) [*4] |-> dataOeN)
    else $error("Control port read drove the bus");
  a_counter_read_drives: assert property (
    (!readN && !chipSelectN && addr != 2'h3) [*4] |-> !dataOeN)
    else $error("Counter read not answered");
  a_bus_idle_off: assert property (readN [*4] |-> dataOeN)
    else $error("Data bus driven while idle");
  a_baud_pair: assert property (transmitBitClock == receiveBitClock)
    else $error("Baud clock outputs differ");
  a_out0_still: assert property (
    (writeN && counterClk[0] && counterGate[0]) [*8] |-> $stable(periodicIrqClockA))
    else $error("Counter 0 output moved without a cause");
  a_out1_still: assert property (
    (writeN && counterClk[1] && counterGate[1] && !cascadeEnable) [*8]
    |-> $stable(periodicClockB))
    else $error("Counter 1 output moved without a cause");
  a_out2_still: assert property (
    (writeN && counterClk[2] && counterGate[2]) [*8] |-> $stable(transmitBitClock))
    else $error("Counter 2 output moved without a cause");

  c_read: cover property ($fell(dataOeN));
  c_baud: cover property ($changed(transmitBitClock));
  c_tc: cover property ($rose(periodicIrqClockA));
  c_cascade: cover property (cascadeEnable && $fell(periodicClockB));
endmodule // itr_readback_timer_monitor

bind itr_readback_timer itr_readback_timer_monitor u_mon (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .chipSelectN(chipSelectN), .readN(readN), .writeN(writeN),
  .addr(addr), .dataOeN(dataOeN), .counterClk(counterClk), .counterGate(counterGate),
  .cascadeEnable(cascadeEnable), .periodicIrqClockA(periodicIrqClockA),
  .periodicClockB(periodicClockB), .transmitBitClock(transmitBitClock),
  .receiveBitClock(receiveBitClock));

// ==== verif/itr_readback_timer_tb.sv ====
`timescale 1ns/1ps

// ========================================
// Testbench for the read-back timer
// ========================================
module itr_readback_timer_tb;
  // Divisor for 4800 baud at 16 times, rounded to nearest.
  localparam integer BAUD_DIV = (1075000 + 38400) / 76800;
  // Divisor for 4800 baud synchronous, also used for isosynchronous at times one.
  localparam integer SYNC_DIV = (1075000 + 2400) / 4800;
  reg ref_clk, sys_rst, cascadeEnable, last, oe;
  reg [2:0] counterClk, counterGate;
  reg [7:0] d;
  wire chipSelectN, readN, writeN, dataOeN;
  wire periodicIrqClockA, periodicClockB, transmitBitClock, receiveBitClock;
  wire [1:0] addr;
  wire [7:0] dataIn, dataOut;
  integer nFail, testsRun, i, prev, gap;

  itr_readback_timer DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .chipSelectN(chipSelectN), .readN(readN), .writeN(writeN), .addr(addr),
    .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN), .counterClk(counterClk),
    .counterGate(counterGate), .cascadeEnable(cascadeEnable),
    .periodicIrqClockA(periodicIrqClockA), .periodicClockB(periodicClockB),
    .transmitBitClock(transmitBitClock), .receiveBitClock(receiveBitClock));

  itr_host_model host (.ref_clk(ref_clk), .dataOut(dataOut), .dataOeN(dataOeN),
    .chipSelectN(chipSelectN), .readN(readN), .writeN(writeN), .addr(addr),
    .dataIn(dataIn));

  always #20 ref_clk = ~ref_clk;

  task finish_test;
    begin
      $display("Checks run %0d, mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task check(input [7:0] seen, input [7:0] exp);
    begin
      testsRun = testsRun + 1;
      if (seen !== exp) begin
        nFail = nFail + 1;
        $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [1:0] a, input [7:0] v);
    host.busWrite(a, v);
  endtask

  task rd(input [1:0] a, input [7:0] exp);
    begin
      host.busRead(a, d, oe);
      check({7'h00, oe}, 8'h01);
      if (oe !== 1'b1)
        finish_test;
      else
        check(d, exp);
    end
  endtask

  // Each pulse gives the masked counters one falling input edge.
  task pulse(input [2:0] m, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(posedge ref_clk);
        counterClk <= ~m;
        repeat (4) @(posedge ref_clk);
        counterClk <= 3'h7;
        repeat (4) @(posedge ref_clk);
      end
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    counterClk = 3'h7;
    counterGate = 3'h7;
    cascadeEnable = 1'b0;
    nFail = 0;
    testsRun = 0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wr(3, 8'h30);
    wr(3, 8'h54);
    wr(3, 8'hB6);
    wr(0, 8'h34);
    wr(0, 8'h12);
    wr(1, 8'h05);
    wr(2, 8'(BAUD_DIV));
    wr(2, 8'h00);
    wr(3, 8'hE2);
    rd(0, 8'h70);
    wr(3, 8'hE4);
    rd(1, 8'hD4);
    wr(3, 8'hC2);
    rd(0, 8'h70);
    rd(0, 8'h00);
    rd(0, 8'h00);
    pulse(3'h7, 1);
    pulse(3'h1, 4);
    wr(3, 8'hD2);
    pulse(3'h1, 3);
    wr(3, 8'hD2);
    wr(3, 8'hE2);
    wr(0, 8'h10);
    wr(0, 8'h00);
    wr(3, 8'hE2);
    rd(0, 8'h30);
    rd(0, 8'h30);
    rd(0, 8'h12);
    rd(0, 8'h2D);
    rd(0, 8'h12);
    wr(3, 8'hDC);
    pulse(3'h7, 1);
    rd(0, 8'h10);
    rd(0, 8'h00);
    rd(1, 8'h05);
    rd(1, 8'h04);
    rd(2, 8'(BAUD_DIV));
    rd(2, 8'h00);
    rd(2, 8'(BAUD_DIV - 2));
    rd(2, 8'h00);
    pulse(3'h1, 15);
    check({7'h00, periodicIrqClockA}, 8'h00);
    pulse(3'h1, 1);
    check({7'h00, periodicIrqClockA}, 8'h01);
    last = transmitBitClock;
    prev = 0;
    gap = 0;
    for (i = 1; i <= 40; i = i + 1) begin
      pulse(3'h4, 1);
      if (transmitBitClock !== last) begin
        gap = i - prev;
        prev = i;
        last = transmitBitClock;
      end
    end
    check(gap[7:0], 8'(BAUD_DIV / 2));
    check({7'h00, receiveBitClock}, {7'h00, transmitBitClock});
    wr(3, 8'h16);
    wr(0, 8'h02);
    cascadeEnable <= 1'b1;
    pulse(3'h1, 7);
    check({7'h00, periodicClockB}, 8'h00);
    rd(1, 8'h01);
    cascadeEnable <= 1'b0;
    wr(3, 8'hB6);
    wr(2, 8'(SYNC_DIV));
    wr(2, 8'(SYNC_DIV >> 8));
    pulse(3'h4, 1);
    wr(3, 8'hC8);
    rd(2, 8'hB6);
    rd(2, 8'(SYNC_DIV));
    rd(2, 8'(SYNC_DIV >> 8));
    host.busRead(2'h3, d, oe);
    check({7'h00, oe}, 8'h00);
    finish_test;
  end
endmodule // itr_readback_timer_tb
